// >>> design/cscr_pkg.sv
/*
 holds: register map, reset values, write masks, field positions and
 code tables of the clock synthesizer control register bank.
 assumes: byte-wide registers reached through a simple host register port.
*/
// Notes on behaviour
// - quad code shifts divider B 45-degree steps
// - low 13 bits signed coarse period shift
// - oscillator bit 0 low enables driver
// - revision reads zero unless ID bits zero
// - low seven bits index 128-bit table
// - bit 7 picks control input or status
// - pin 2 resets to 0x70
// - pin 6 resets to 0x72, others unused
// - five-bit holdover delay code, log scale
// - edge field picks edge or pulse middle
// - three-bit code picks PLL capture range
// - mask bit 4 low blocks monitor holdover
// - mask bit 0 low hides reference alarm
// - monitor accepts inside, rejects outside, holds between
// - range code picks accept/reject limits
package cscr_pkg;
   localparam int REG_COUNT = 16;
   localparam int PIN_COUNT = 7;
   localparam int TABLE_BITS = 128;
   localparam int CNT_W = 16;
   // register indices into the bank
   localparam int IX_PHASE_HI = 0;
   localparam int IX_PHASE_LO = 1;
   localparam int IX_OSC = 2;
   localparam int IX_REV = 3;
   localparam int IX_PIN0 = 4;
   localparam int IX_PLL_CTRL = 11;
   localparam int IX_PLL_RANGE = 12;
   localparam int IX_MON_HO = 13;
   localparam int IX_MON_FAIL = 14;
   localparam int IX_MON_RANGE = 15;
   localparam logic [7:0] REG_ADDR [REG_COUNT] = '{
      8'hC1, 8'hC2, 8'hC3, 8'hC6, 8'hE0, 8'hE1, 8'hE2, 8'hE3,
      8'hE4, 8'hE5, 8'hE6, 8'hEC, 8'hED, 8'hF4, 8'hF5, 8'hF7};
   localparam logic [7:0] REG_RESET [REG_COUNT] = '{
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h70, 8'h00,
      8'h00, 8'h00, 8'h72, 8'h00, 8'h07, 8'hF0, 8'h00, 8'h33};
   localparam logic [7:0] REG_WMASK [REG_COUNT] = '{
      8'hFF, 8'hFF, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'hFF, 8'hFF, 8'hFF, 8'hDF, 8'h07, 8'h10, 8'h01, 8'h07};
   // field positions
   localparam int QUAD_LSB = 5;
   localparam int COARSE_HI_MSB = 4;
   localparam int OSC_DISABLE_BIT = 0;
   localparam int PIN_DIR_BIT = 7;
   localparam int HO_CODE_MSB = 4;
   localparam int EDGE_LSB = 6;
   localparam int MON_HO_BIT = 4;
   localparam int MON_FAIL_BIT = 0;
   typedef enum logic [1:0] {
      CSCR_EDGE_RISE = 2'h0,
      CSCR_EDGE_FALL = 2'h1,
      CSCR_EDGE_LOW_PULSE = 2'h2,
      CSCR_EDGE_HIGH_PULSE = 2'h3
   } cscr_edge_e;
   typedef enum logic {
      CSCR_PM_IDLE = 1'h0,
      CSCR_PM_COUNT = 1'h1
   } cscr_pm_e;
   localparam logic [2:0] RANGE_UNLIMITED = 3'h7;
   // capture range in ppm, codes 5 and 6 reserved
   localparam logic [8:0] PULL_PPM [8] = '{
      9'h00C, 9'h034, 9'h053, 9'h082, 9'h190, 9'h000, 9'h000, 9'h000};
   // monitor limits in tenths of a ppm
   localparam logic [10:0] MON_ACCEPT [8] = '{
      11'h05C, 11'h190, 11'h280, 11'h3E8, 11'h08A, 11'h0F6, 11'h150, 11'h208};
   localparam logic [10:0] MON_REJECT [8] = '{
      11'h078, 11'h208, 11'h33E, 11'h514, 11'h0B4, 11'h140, 11'h1DB, 11'h2A3};
endpackage : cscr_pkg

// >>> design/cscr_pin_map.sv
/*
 holds: one multipurpose pin's function decode.
 assumes: pin level already synchronised, status table on sys_clk.
*/
`timescale 1ns/1ps
module cscr_pin_map #(
   parameter int TABLE_BITS = 128
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [7:0] func,
   input wire logic pin_level,
   input wire logic [TABLE_BITS-1:0] status_table,
   output logic pin_out,
   output logic pin_oe_n,
   output logic [TABLE_BITS-1:0] ctrl_hit
);
   if (TABLE_BITS != 128) begin : g_chk
      $error("table must hold 128 bits");
   end
   logic [6:0] idx;
   logic is_status;
   logic next_out;
   logic next_oe_n;
   assign idx = func[6:0];
   assign is_status = func[cscr_pkg::PIN_DIR_BIT];
   // status pins drive the indexed bit, control pins feed the table
   always_comb begin
      next_out = 1'b0;
      next_oe_n = 1'b1;
      ctrl_hit = '0;
      if (is_status) begin
         next_out = status_table[idx];
         next_oe_n = 1'b0;
      end else if (func != 8'h00) begin
         ctrl_hit[idx] = pin_level;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pin_out <= 1'b0;
         pin_oe_n <= 1'b1;
      end else if (ce) begin
         pin_out <= next_out;
         pin_oe_n <= next_oe_n;
      end
   end
   status_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
      ce && is_status |=> !pin_oe_n && pin_out == $past(status_table[idx]))
      else $error("status pin not driving indexed bit");
   control_float_a: assert property (@(posedge sys_clk) disable iff (rst)
      ce && !is_status |=> pin_oe_n && !pin_out)
      else $error("control pin is driven");
endmodule : cscr_pin_map

// >>> design/cscr_freq_mon.sv
/*
 holds: accept/reject hysteresis of the reference frequency monitor.
 assumes: offset magnitude in tenths of a ppm from logic on sys_clk.
*/
`timescale 1ns/1ps
module cscr_freq_mon (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [2:0] range_code,
   input wire logic [10:0] offset,
   input wire logic offset_valid,
   output logic accepted
);
   logic next_accepted;
   logic [10:0] acc_lim;
   logic [10:0] rej_lim;
   assign acc_lim = cscr_pkg::MON_ACCEPT[range_code];
   assign rej_lim = cscr_pkg::MON_REJECT[range_code];
   // inside accept wins, outside reject loses, between holds
   always_comb begin
      next_accepted = accepted;
      if (offset_valid) begin
         if (offset <= acc_lim) begin
            next_accepted = 1'b1;
         end else if (offset > rej_lim) begin
            next_accepted = 1'b0;
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         accepted <= 1'b0;
      end else if (ce) begin
         accepted <= next_accepted;
      end
   end
   sequence s_inside;
      ce && offset_valid && offset <= acc_lim;
   endsequence
   sequence s_outside;
      ce && offset_valid && offset > rej_lim;
   endsequence
   mon_accept_a: assert property (@(posedge sys_clk) disable iff (rst)
      s_inside |=> accepted)
      else $error("offset inside range not accepted");
   mon_reject_a: assert property (@(posedge sys_clk) disable iff (rst)
      s_outside |=> !accepted)
      else $error("offset outside range not rejected");
   mon_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      ce && offset_valid && offset > acc_lim && offset <= rej_lim |=> $stable(accepted))
      else $error("monitor changed state between limits");
   mon_limit_a: assert property (@(posedge sys_clk) disable iff (rst)
      range_code == 3'h0 && ce && offset_valid && offset == 11'h078 |=> $stable(accepted))
      else $error("code 0 reject limit wrong");
endmodule : cscr_freq_mon

// >>> design/cscr_top.sv
/*
 holds: the control register bank and the logic that its fields steer.
 assumes: host port decoded to byte read/write strobes on sys_clk;
 status table, ID revision bits and offset from logic on sys_clk;
 gpio and reference come from pins and are synchronised here.
*/
`timescale 1ns/1ps
module cscr_top #(
   parameter logic [7:0] REV_RESET = 8'h5A, // arbitrary value
   parameter int CNT_W = cscr_pkg::CNT_W
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [1:0] id_rev_bits,
   input wire logic [6:0] gpio_in,
   output logic [6:0] gpio_out,
   output logic [6:0] gpio_oe_n,
   input wire logic [127:0] status_table,
   output logic [127:0] control_table,
   output logic [2:0] div_b_quad_advance,
   output logic [12:0] div_b_coarse_shift,
   output logic osc_driver_enable,
   output logic [4:0] holdover_delay_code,
   input wire logic ref_in,
   output logic ref_event,
   output logic [CNT_W-1:0] ref_event_lag,
   output logic [8:0] pll_range_ppm,
   output logic pll_range_unlimited,
   output logic pll_range_reserved,
   input wire logic [10:0] ref_offset,
   input wire logic ref_offset_valid,
   output logic ref_accepted,
   output logic ref_fail_alarm,
   output logic holdover_request
);
   if (CNT_W < 2) begin : g_chk
      $error("pulse counter needs two bits at least");
   end

   // register bank storage
   logic [7:0] bank [cscr_pkg::REG_COUNT];
   logic [7:0] next_bank [cscr_pkg::REG_COUNT];
   logic [7:0] next_rdata;
   logic next_rvalid;

   // write: only writable bits change, reserved keep reset value
   always_comb begin
      for (int i = 0; i < cscr_pkg::REG_COUNT; i++) begin
         next_bank[i] = bank[i];
         if (reg_wr && reg_addr == cscr_pkg::REG_ADDR[i]) begin
            next_bank[i] = (reg_wdata & cscr_pkg::REG_WMASK[i]) |
               (bank[i] & ~cscr_pkg::REG_WMASK[i]);
         end
      end
   end

   // bank registers with their reset values
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < cscr_pkg::REG_COUNT; i++) begin
            bank[i] <= cscr_pkg::REG_RESET[i];
         end
         bank[cscr_pkg::IX_REV] <= REV_RESET;
      end else if (ce) begin
         for (int i = 0; i < cscr_pkg::REG_COUNT; i++) begin
            bank[i] <= next_bank[i];
         end
      end
   end

   // read: one cycle later, unmapped reads give zero
   always_comb begin
      next_rdata = 8'h00;
      next_rvalid = reg_rd;
      if (reg_rd) begin
         for (int i = 0; i < cscr_pkg::REG_COUNT; i++) begin
            if (reg_addr == cscr_pkg::REG_ADDR[i]) begin
               next_rdata = bank[i];
            end
         end
         if (reg_addr == cscr_pkg::REG_ADDR[cscr_pkg::IX_REV] &&
             id_rev_bits != 2'h0) begin
            next_rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else if (ce) begin
         reg_rdata <= next_rdata;
         reg_rvalid <= next_rvalid;
      end
   end

   // decoded control fields
   logic [2:0] quad_code;
   logic [2:0] range_code;
   logic [2:0] next_quad;
   logic [12:0] next_coarse;
   logic next_osc_en;
   logic [4:0] next_ho_code;
   logic [8:0] next_ppm;
   logic next_unlim;
   logic next_resv;
   assign quad_code = bank[cscr_pkg::IX_PHASE_HI][7:cscr_pkg::QUAD_LSB];
   assign range_code = bank[cscr_pkg::IX_PLL_RANGE][2:0];

   // field decode: advance in 45 degree steps, signed periods, range
   always_comb begin
      next_quad = 3'h0 - quad_code;
      next_coarse = {bank[cscr_pkg::IX_PHASE_HI][cscr_pkg::COARSE_HI_MSB:0],
         bank[cscr_pkg::IX_PHASE_LO]};
      next_osc_en = !bank[cscr_pkg::IX_OSC][cscr_pkg::OSC_DISABLE_BIT];
      next_ho_code = bank[cscr_pkg::IX_PLL_CTRL][cscr_pkg::HO_CODE_MSB:0];
      next_ppm = cscr_pkg::PULL_PPM[range_code];
      next_unlim = 1'b0;
      next_resv = 1'b0;
      case (range_code)
         cscr_pkg::RANGE_UNLIMITED: next_unlim = 1'b1;
         3'h5, 3'h6: next_resv = 1'b1;
         default: next_unlim = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_b_quad_advance <= 3'h0;
         div_b_coarse_shift <= 13'h0000;
         osc_driver_enable <= 1'b1;
         holdover_delay_code <= 5'h00;
         pll_range_ppm <= 9'h000;
         pll_range_unlimited <= 1'b1;
         pll_range_reserved <= 1'b0;
      end else if (ce) begin
         div_b_quad_advance <= next_quad;
         div_b_coarse_shift <= next_coarse;
         osc_driver_enable <= next_osc_en;
         holdover_delay_code <= next_ho_code;
         pll_range_ppm <= next_ppm;
         pll_range_unlimited <= next_unlim;
         pll_range_reserved <= next_resv;
      end
   end

   // gpio synchronisers, first stage read only by second
   logic [6:0] gpio_meta;
   logic [6:0] gpio_sync;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         gpio_meta <= 7'h00;
         gpio_sync <= 7'h00;
      end else if (ce) begin
         gpio_meta <= gpio_in;
         gpio_sync <= gpio_meta;
      end
   end

   // one function decoder per pin
   logic [127:0] ctrl_hit [cscr_pkg::PIN_COUNT];
   logic [127:0] next_control;
   for (genvar p = 0; p < cscr_pkg::PIN_COUNT; p++) begin : g_pin
      cscr_pin_map #(
         .TABLE_BITS(cscr_pkg::TABLE_BITS)
      ) u_pin (
         .sys_clk(sys_clk),
         .rst(rst),
         .ce(ce),
         .func(bank[cscr_pkg::IX_PIN0 + p]),
         .pin_level(gpio_sync[p]),
         .status_table(status_table),
         .pin_out(gpio_out[p]),
         .pin_oe_n(gpio_oe_n[p]),
         .ctrl_hit(ctrl_hit[p])
      );
   end

   // control table: any control pin mapped to a bit sets it
   always_comb begin
      next_control = 128'h0;
      for (int p = 0; p < cscr_pkg::PIN_COUNT; p++) begin
         next_control = next_control | ctrl_hit[p];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         control_table <= 128'h0;
      end else if (ce) begin
         control_table <= next_control;
      end
   end

   // frequency monitor and alarm masking
   logic next_fail;
   logic next_ho_req;
   cscr_freq_mon u_mon (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .range_code(bank[cscr_pkg::IX_MON_RANGE][2:0]),
      .offset(ref_offset),
      .offset_valid(ref_offset_valid),
      .accepted(ref_accepted)
   );
   always_comb begin
      next_fail = !ref_accepted &&
         bank[cscr_pkg::IX_MON_FAIL][cscr_pkg::MON_FAIL_BIT];
      next_ho_req = !ref_accepted &&
         bank[cscr_pkg::IX_MON_HO][cscr_pkg::MON_HO_BIT];
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ref_fail_alarm <= 1'b0;
         holdover_request <= 1'b0;
      end else if (ce) begin
         ref_fail_alarm <= next_fail;
         holdover_request <= next_ho_req;
      end
   end

   // reference synchroniser and edge history
   logic ref_meta;
   logic ref_sync;
   logic ref_last;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ref_meta <= 1'b0;
         ref_sync <= 1'b0;
         ref_last <= 1'b0;
      end else if (ce) begin
         ref_meta <= ref_in;
         ref_sync <= ref_meta;
         ref_last <= ref_sync;
      end
   end

   // reference event: edge now, or pulse end with half-width lag
   cscr_pkg::cscr_edge_e edge_mode;
   cscr_pkg::cscr_pm_e pm_state;
   cscr_pkg::cscr_pm_e next_pm_state;
   logic [CNT_W-1:0] pulse_cnt;
   logic [CNT_W-1:0] next_cnt;
   logic rise;
   logic fall;
   logic start_edge;
   logic end_edge;
   logic next_event;
   logic [CNT_W-1:0] next_lag;
   assign edge_mode = cscr_pkg::cscr_edge_e'(
      bank[cscr_pkg::IX_PLL_CTRL][7:cscr_pkg::EDGE_LSB]);
   assign rise = ref_sync && !ref_last;
   assign fall = !ref_sync && ref_last;
   assign start_edge = (edge_mode == cscr_pkg::CSCR_EDGE_HIGH_PULSE) ? rise : fall;
   assign end_edge = (edge_mode == cscr_pkg::CSCR_EDGE_HIGH_PULSE) ? fall : rise;

   always_comb begin
      next_pm_state = pm_state;
      next_cnt = pulse_cnt;
      next_event = 1'b0;
      next_lag = '0;
      case (edge_mode)
         cscr_pkg::CSCR_EDGE_RISE: begin
            next_event = rise;
            next_pm_state = cscr_pkg::CSCR_PM_IDLE;
         end
         cscr_pkg::CSCR_EDGE_FALL: begin
            next_event = fall;
            next_pm_state = cscr_pkg::CSCR_PM_IDLE;
         end
         default: begin
            case (pm_state)
               cscr_pkg::CSCR_PM_IDLE: begin
                  if (start_edge) begin
                     next_pm_state = cscr_pkg::CSCR_PM_COUNT;
                     next_cnt = {{(CNT_W-1){1'b0}}, 1'b1};
                  end
               end
               cscr_pkg::CSCR_PM_COUNT: begin
                  if (end_edge) begin
                     next_event = 1'b1;
                     next_lag = pulse_cnt >> 1;
                     next_pm_state = cscr_pkg::CSCR_PM_IDLE;
                  end else if (pulse_cnt != '1) begin
                     next_cnt = pulse_cnt + 1'b1;
                  end
               end
               default: next_pm_state = cscr_pkg::CSCR_PM_IDLE;
            endcase
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pm_state <= cscr_pkg::CSCR_PM_IDLE;
         pulse_cnt <= '0;
         ref_event <= 1'b0;
         ref_event_lag <= '0;
      end else if (ce) begin
         pm_state <= next_pm_state;
         pulse_cnt <= next_cnt;
         ref_event <= next_event;
         ref_event_lag <= next_lag;
      end
   end

   // checks
   sequence s_rise_mode;
      ce && edge_mode == cscr_pkg::CSCR_EDGE_RISE && rise;
   endsequence
   sequence s_pulse_end;
      ce && edge_mode[1] && pm_state == cscr_pkg::CSCR_PM_COUNT && end_edge;
   endsequence
   quad_map_a: assert property (@(posedge sys_clk) disable iff (rst)
      ce |=> 3'(div_b_quad_advance + $past(quad_code)) == 3'h0)
      else $error("quadrature advance wrong");
   coarse_shift_a: assert property (@(posedge sys_clk) disable iff (rst)
      ce |=> div_b_coarse_shift == $past({bank[cscr_pkg::IX_PHASE_HI][4:0],
      bank[cscr_pkg::IX_PHASE_LO]}))
      else $error("coarse shift wrong");
   osc_driver_a: assert property (@(posedge sys_clk) disable iff (rst)
      ce |=> osc_driver_enable != $past(bank[cscr_pkg::IX_OSC][0]))
      else $error("oscillator driver sense wrong");
   rev_hide_a: assert property (@(posedge sys_clk) disable iff (rst)
      ce && reg_rd && reg_addr == 8'hC6 && id_rev_bits != 2'h0
      |=> reg_rvalid && reg_rdata == 8'h00)
      else $error("revision not hidden");
   pin_reset_a: assert property (@(posedge sys_clk)
      rst |=> bank[6] == 8'h70 && bank[10] == 8'h72 && bank[4] == 8'h00)
      else $error("pin function reset wrong");
   reserved_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
      ce |=> bank[cscr_pkg::IX_MON_HO][3:0] == 4'h0 &&
      bank[cscr_pkg::IX_MON_RANGE][7:3] == 5'h06)
      else $error("reserved bits changed");
   rise_event_a: assert property (@(posedge sys_clk) disable iff (rst)
      s_rise_mode |=> ref_event && ref_event_lag == '0)
      else $error("rising edge event missing");
   pulse_mid_a: assert property (@(posedge sys_clk) disable iff (rst)
      s_pulse_end |=> ref_event && ref_event_lag == ($past(pulse_cnt) >> 1))
      else $error("pulse midpoint lag wrong");
   range_code_a: assert property (@(posedge sys_clk) disable iff (rst)
      ce && range_code == 3'h7 |=> pll_range_unlimited && pll_range_ppm == 9'h000)
      else $error("unlimited range not flagged");
   alarm_mask_a: assert property (@(posedge sys_clk) disable iff (rst)
      ref_fail_alarm |-> $past(bank[cscr_pkg::IX_MON_FAIL][0]))
      else $error("masked alarm shown");
   ho_mask_a: assert property (@(posedge sys_clk) disable iff (rst)
      ce && !bank[cscr_pkg::IX_MON_HO][4] |=> !holdover_request)
      else $error("masked holdover request");
endmodule : cscr_top

// >>> verification/cscr_host_model.sv
/*
 holds: host processor model driving the byte register port of the bank.
 assumes: same sys_clk as the bank; read answer one edge after the strobe.
*/
`timescale 1ns/1ps
module cscr_host_model (
   input wire logic sys_clk,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   // idle bus at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // one strobe cycle; afterwards the bus shows inverted values
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_wr = wr;
      reg_rd = ~wr;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : access
   // read data stands in the cycle after the taking edge
   task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
      access(1'b0, a, 8'h00);
      d = reg_rdata;
      ok = reg_rvalid;
   endtask : read
   // oscillator source choice, reserved bits kept at reset value
   task automatic select_osc(input logic module_osc);
      access(1'b1, 8'hC3, {7'h00, module_osc});
   endtask : select_osc
endmodule : cscr_host_model

// >>> verification/test_clock_synth_ctrl_regs.sv
/*
 holds: self-checking bench of the control register bank.
 assumes: cscr_top and cscr_host_model compiled; 125 MHz sys_clk.
*/
`timescale 1ns/1ps
module test_clock_synth_ctrl_regs;
   logic sys_clk, rst, ce, reg_wr, reg_rd, reg_rvalid, ref_in, ref_event, ref_offset_valid;
   logic osc_driver_enable, pll_range_unlimited, pll_range_reserved, ref_accepted;
   logic ref_fail_alarm, holdover_request;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [1:0] id_rev_bits;
   logic [6:0] gpio_in, gpio_out, gpio_oe_n;
   logic [127:0] status_table, control_table;
   logic [2:0] div_b_quad_advance;
   logic [12:0] div_b_coarse_shift;
   logic [4:0] holdover_delay_code;
   logic [15:0] ref_event_lag;
   logic [8:0] pll_range_ppm;
   logic [10:0] ref_offset;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   localparam logic [7:0] REV = 8'hA6; // arbitrary value
   cscr_top #(.REV_RESET(REV)) cscr_top_i (.sys_clk(sys_clk), .rst(rst), .ce(ce),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .id_rev_bits(id_rev_bits),
      .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
      .status_table(status_table), .control_table(control_table),
      .div_b_quad_advance(div_b_quad_advance), .div_b_coarse_shift(div_b_coarse_shift),
      .osc_driver_enable(osc_driver_enable), .holdover_delay_code(holdover_delay_code),
      .ref_in(ref_in), .ref_event(ref_event), .ref_event_lag(ref_event_lag),
      .pll_range_ppm(pll_range_ppm), .pll_range_unlimited(pll_range_unlimited),
      .pll_range_reserved(pll_range_reserved), .ref_offset(ref_offset),
      .ref_offset_valid(ref_offset_valid), .ref_accepted(ref_accepted),
      .ref_fail_alarm(ref_fail_alarm), .holdover_request(holdover_request));
   cscr_host_model cscr_host_model_i (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata));
   // free-running clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         tally_and_finish();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish();
      if (fails == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cscr_host_model_i.access(1'b1, a, d);
      repeat (2) @(negedge sys_clk);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      cscr_host_model_i.read(a, d, ok);
      check({ok, d}, {1'b1, exp});
   endtask : rd_chk
   task automatic mon(input logic [10:0] off, input logic exp);
      @(negedge sys_clk);
      ref_offset = off;
      ref_offset_valid = 1'b1;
      @(negedge sys_clk);
      ref_offset_valid = 1'b0;
      repeat (2) @(negedge sys_clk);
      check(ref_accepted, exp);
   endtask : mon
   // reset values of every register except the revision, and the driver enable, unlimited range and holdover request outputs
   task automatic t_reset;
      for (int i = 0; i < cscr_pkg::REG_COUNT; i++)
         if (i != cscr_pkg::IX_REV) rd_chk(cscr_pkg::REG_ADDR[i], cscr_pkg::REG_RESET[i]);
      rd_chk(8'hE2, 8'h70);
      rd_chk(8'hE6, 8'h72);
      rd_chk(8'hD0, 8'h00);
      check({osc_driver_enable, pll_range_unlimited, holdover_request}, 3'h7);
   endtask : t_reset
   // quadrature codes and signed coarse shift
   task automatic t_divb;
      logic [2:0] adv [8] = '{3'h0, 3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
      wr(8'hC2, 8'hA0);
      for (int q = 0; q < 8; q++) begin
         wr(8'hC1, {q[2:0], 5'h15});
         check(div_b_quad_advance, adv[q]);
         check(div_b_coarse_shift, 13'h15A0);
      end
   endtask : t_divb
   // oscillator driver bit, reserved bits and frozen clock enable
   task automatic t_osc;
      cscr_host_model_i.select_osc(1'b1);
      repeat (2) @(negedge sys_clk);
      check(osc_driver_enable, 1'b0);
      wr(8'hC3, 8'hFE);
      check(osc_driver_enable, 1'b1);
      rd_chk(8'hC3, 8'h00);
      ce = 1'b0;
      wr(8'hC3, 8'h01);
      ce = 1'b1;
      rd_chk(8'hC3, 8'h00);
   endtask : t_osc
   // revision shown only while the identity revision bits are zero
   task automatic t_rev;
      id_rev_bits = 2'h1;
      rd_chk(8'hC6, 8'h00);
      id_rev_bits = 2'h0;
      rd_chk(8'hC6, REV);
   endtask : t_rev
   // default control pins and a status pin
   task automatic t_pins;
      gpio_in = 7'h44;
      repeat (4) @(negedge sys_clk);
      check(control_table[8'h72:8'h70], 3'h5);
      gpio_in = 7'h00;
      wr(8'hE0, 8'h85);
      status_table[5] = 1'b1;
      repeat (3) @(negedge sys_clk);
      check({gpio_out[0], gpio_oe_n[0], control_table[8'h72:8'h70]}, 5'h10);
      status_table[5] = 1'b0;
      repeat (2) @(negedge sys_clk);
      check(gpio_out[0], 1'b0);
   endtask : t_pins
   // capture range codes and holdover delay code
   task automatic t_range;
      logic [8:0] ppm [8] = '{9'h00C, 9'h034, 9'h053, 9'h082, 9'h190, 9'h0, 9'h0, 9'h0};
      for (int c = 0; c < 8; c++) begin
         wr(8'hED, {5'h1F, c[2:0]});
         check({pll_range_reserved, pll_range_unlimited, pll_range_ppm},
            {c == 5 || c == 6, c == 7, ppm[c]});
      end
      wr(8'hEC, 8'h3D);
      check(holdover_delay_code, 5'h1D);
      rd_chk(8'hEC, 8'h1D);
   endtask : t_range
   // rising, falling, low-pulse and high-pulse reference events
   task automatic t_edge;
      logic [1:0] m;
      int n, at;
      logic [15:0] lag;
      for (int k = 0; k < 4; k++) begin
         m = k[1:0];
         wr(8'hEC, {m, 6'h00});
         n = 0;
         at = 0;
         lag = 16'h0;
         for (int t = 0; t < 24; t++) begin
            ref_in = (t >= 4 && t < 14) ^ (m == 2'h2);
            @(negedge sys_clk);
            if (ref_event === 1'b1) begin
               n++;
               at = t;
               lag = ref_event_lag;
            end
         end
         check(n, 1);
         check({at >= 10, lag >= 4 && lag <= 6}, {m != 2'h0, m[1]});
      end
   endtask : t_edge
   // monitor hysteresis, masks and every range code
   task automatic t_mon;
      logic [10:0] acc [8] = '{92, 400, 640, 1000, 138, 246, 336, 520};
      logic [10:0] rej [8] = '{120, 520, 830, 1300, 180, 320, 475, 675};
      mon(11'd1000, 1'b1);
      mon(11'd1301, 1'b0);
      mon(11'd1200, 1'b0);
      check({ref_fail_alarm, holdover_request}, 2'h1);
      wr(8'hF5, 8'h01);
      wr(8'hF4, 8'h00);
      check({ref_fail_alarm, holdover_request}, 2'h2);
      rd_chk(8'hF4, 8'hE0);
      for (int c = 0; c < 8; c++) begin
         wr(8'hF7, c[7:0]);
         mon(acc[c], 1'b1);
         mon(rej[c], 1'b1);
         mon(rej[c] + 11'd1, 1'b0);
      end
   endtask : t_mon
   // inputs at time zero, reset, then the scenarios
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      id_rev_bits = 2'h0;
      gpio_in = 7'h00;
      status_table = '0;
      ref_in = 1'b0;
      ref_offset = 11'h000;
      ref_offset_valid = 1'b0;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      t_reset();
      t_divb();
      t_osc();
      t_rev();
      t_pins();
      t_range();
      t_edge();
      t_mon();
      tally_and_finish();
   end
endmodule : test_clock_synth_ctrl_regs
